// ===== common/vpu_consts.vh
// Overview of operation
// - slides with start index at or beyond active length write nothing.
// - slide mask bit i gates destination element i; inactive follows mask policy.
// - elements at or past active length follow the tail policy.
// - slide offset is unsigned scalar or zero-extended 5-bit immediate, never truncated.
// - slide-up writes element i+offset from source i, offset up to active length.
// - slide-up with destination overlapping source is reserved.
// - slide-down writes element i from source i+offset, up to active length.
// - one-element slide-up puts the scalar in element 0 when active.
// - one-element slide-up keeps elements below start, copies source i-1 above.
// - one-element slide-up with overlapping destination and source is reserved.
// - inserted scalar is sign-extended or cut to element width.
// - one-element slide-down copies source i+1, scalar into last active element.
// - float one-element slides use the float scalar, otherwise identical.
// - vector gather indices are unsigned, any source below maximum count readable.
// - gather index at or past maximum element count yields zero.
// - halfword-index gather reads 16-bit indices with their own grouping.
// - scalar and immediate gather splat one unsigned-indexed element, zero if out of range.
// - gather with destination overlapping any source group is reserved.
// - compress packs selected leading elements in order from element 0.
// - masked compress encoding is reserved.
// - compress overlapping source or mask register is reserved.
// - compress with non-zero start is illegal; traps report start index zero.
`ifndef VPU_CONSTS_VH
`define VPU_CONSTS_VH
`define VPU_OP_W           4
`define VPU_OP_SLIDE_UP    4'h0
`define VPU_OP_SLIDE_DN    4'h1
`define VPU_OP_UP_INS_INT  4'h2
`define VPU_OP_UP_INS_FP   4'h3
`define VPU_OP_DN_INS_INT  4'h4
`define VPU_OP_DN_INS_FP   4'h5
`define VPU_OP_PICK_VEC    4'h6
`define VPU_OP_PICK_HALF   4'h7
`define VPU_OP_PICK_SCAL   4'h8
`define VPU_OP_COMPRESS    4'h9
`define VPU_IMM_W          5
`define VPU_IDX16_W        16
`define VPU_REG_NUM_W      5
`define VPU_GRP_W          4
`define VPU_MASK_GRP       4'h1
`endif

// ===== hdl/vpu_elem_pick.v
`timescale 1ns/1ps
module vpu_elem_pick #(
  parameter EW = 32,
  parameter NE = 8,
  parameter IW = 16
) (
  // vector and selection
  input  wire [NE*EW-1:0] sel_vec,
  input  wire [IW-1:0]    sel_idx,
  input  wire [IW-1:0]    sel_lim,
  // picked element
  output reg  [EW-1:0]    sel_data
);
  localparam IXW = $clog2(NE);
  localparam [IW-1:0] NE_W = NE;

  // out of range gives zero rather than wrapping into a low element
  always @*
  begin
    sel_data = {EW{1'b0}};
    if (sel_idx < sel_lim && sel_idx < NE_W)
      sel_data = sel_vec[sel_idx[IXW-1:0]*EW +: EW];
  end
endmodule

// ===== hdl/vpu_permute.v
`timescale 1ns/1ps
`include "vpu_consts.vh"
module vpu_permute #(
  parameter EW   = 32,
  parameter NE   = 8,
  parameter SCALAR_WIDTH = 64,
  parameter FLEN = 32
) (
  // clock and reset
  input  wire                      sys_clk,
  input  wire                      arst_n,
  // operation request
  input  wire                      start_req,
  input  wire [`VPU_OP_W-1:0]      op_code,
  input  wire                      use_imm,
  input  wire [`VPU_IMM_W-1:0]     imm_offset,
  input  wire                      unmasked_flag,
  input  wire                      tail_agnostic,
  input  wire                      mask_agnostic,
  // length state
  input  wire [$clog2(NE):0]       active_length,
  input  wire [$clog2(NE):0]       start_index,
  input  wire [$clog2(NE):0]       max_element_count,
  // register numbers for the overlap check
  input  wire [`VPU_REG_NUM_W-1:0] dst_reg,
  input  wire [`VPU_REG_NUM_W-1:0] src_reg,
  input  wire [`VPU_REG_NUM_W-1:0] idx_reg,
  input  wire [`VPU_GRP_W-1:0]     data_grp,
  input  wire [`VPU_GRP_W-1:0]     idx_grp,
  // operands
  input  wire [SCALAR_WIDTH-1:0]           scalar_int,
  input  wire [FLEN-1:0]           scalar_float,
  input  wire [NE*EW-1:0]          src_data,
  input  wire [NE*EW-1:0]          idx_data,
  input  wire [NE*16-1:0]          idx16_data,
  input  wire [NE-1:0]             mask_bits,
  input  wire [NE*EW-1:0]          dest_old,
  // results
  output reg                       busy_reg,
  output reg                       done_reg,
  output reg                       reserved_reg,
  output reg                       illegal_reg,
  output reg  [$clog2(NE):0]       fault_start_reg,
  output reg  [NE*EW-1:0]          result_reg,
  output reg  [NE-1:0]             elem_we_reg
);
  localparam IXW = $clog2(NE);
  localparam CW  = IXW + 1;
  localparam AW  = SCALAR_WIDTH + EW + 1;
  localparam [CW-1:0] LAST = NE - 1;
  localparam [2:0] ST_IDLE = 3'h1;
  localparam [2:0] ST_RUN  = 3'h2;
  localparam [2:0] ST_TAIL = 3'h4;

  reg [2:0]            state_reg;
  reg [`VPU_OP_W-1:0]  op_reg;
  reg [SCALAR_WIDTH-1:0]       off_reg;
  reg                  um_reg;
  reg                  ta_reg;
  reg                  ma_reg;
  reg [CW-1:0]         i_reg;
  reg [CW-1:0]         wptr_reg;
  reg [AW-1:0]         sidx;
  reg [EW-1:0]         elem_val;
  reg                  rsv;

  wire [AW-1:0] iw   = {{(AW-CW){1'b0}}, i_reg};
  wire [AW-1:0] vlw  = {{(AW-CW){1'b0}}, active_length};
  wire [AW-1:0] mxw  = {{(AW-CW){1'b0}}, max_element_count};
  wire [AW-1:0] offw = {{(EW+1){1'b0}}, off_reg};
  wire [AW-1:0] one  = {{(AW-1){1'b0}}, 1'b1};
  wire [SCALAR_WIDTH-1:0] off_in = use_imm ? {{(SCALAR_WIDTH-`VPU_IMM_W){1'b0}}, imm_offset} : scalar_int;
  wire [IXW-1:0]  ix   = i_reg[IXW-1:0];
  wire [IXW-1:0]  wx   = wptr_reg[IXW-1:0];
  wire [EW-1:0]   pick_data;
  wire [EW-1:0]   ones = {EW{1'b1}};

  // sign-extend when narrower, keep the low bits when wider
  wire [EW+SCALAR_WIDTH-1:0] ext_int = {{EW{scalar_int[SCALAR_WIDTH-1]}}, scalar_int};
  wire [EW+FLEN-1:0] ext_fp  = {{EW{scalar_float[FLEN-1]}}, scalar_float};
  wire fp_op = (op_reg == `VPU_OP_UP_INS_FP) || (op_reg == `VPU_OP_DN_INS_FP);
  wire [EW-1:0] ins_val = fp_op ? ext_fp[EW-1:0] : ext_int[EW-1:0];

  wire is_up  = (op_reg == `VPU_OP_UP_INS_INT) || (op_reg == `VPU_OP_UP_INS_FP);
  wire is_dn1 = (op_reg == `VPU_OP_DN_INS_INT) || (op_reg == `VPU_OP_DN_INS_FP);
  wire is_cmp = (op_reg == `VPU_OP_COMPRESS);

  function ovl;
    input [`VPU_REG_NUM_W-1:0] a;
    input [`VPU_GRP_W-1:0]     na;
    input [`VPU_REG_NUM_W-1:0] b;
    input [`VPU_GRP_W-1:0]     nb;
    reg   [`VPU_REG_NUM_W:0]   ae;
    reg   [`VPU_REG_NUM_W:0]   be;
    begin
      ae = {1'b0, a} + {2'b00, na};
      be = {1'b0, b} + {2'b00, nb};
      ovl = ({1'b0, a} < be) && ({1'b0, b} < ae);
    end
  endfunction

  // reserved encodings judged on the live request
  always @*
  begin
    rsv = 1'b0;
    case (op_code)
      `VPU_OP_SLIDE_UP, `VPU_OP_UP_INS_INT, `VPU_OP_UP_INS_FP:
        rsv = ovl(dst_reg, data_grp, src_reg, data_grp);
      `VPU_OP_PICK_VEC:
        rsv = ovl(dst_reg, data_grp, src_reg, data_grp) || ovl(dst_reg, data_grp, idx_reg, data_grp);
      `VPU_OP_PICK_HALF:
        rsv = ovl(dst_reg, data_grp, src_reg, data_grp) || ovl(dst_reg, data_grp, idx_reg, idx_grp);
      `VPU_OP_PICK_SCAL:
        rsv = ovl(dst_reg, data_grp, src_reg, data_grp);
      `VPU_OP_COMPRESS:
        rsv = !unmasked_flag || ovl(dst_reg, data_grp, src_reg, data_grp)
              || ovl(dst_reg, data_grp, idx_reg, `VPU_MASK_GRP);
      default:
        rsv = 1'b0;
    endcase
  end

  // source position for element i; wide sums so huge offsets land out of range
  always @*
  begin
    sidx = iw;
    case (op_reg)
      `VPU_OP_SLIDE_UP:   sidx = iw - offw;
      `VPU_OP_SLIDE_DN:   sidx = iw + offw;
      `VPU_OP_UP_INS_INT: sidx = iw - one;
      `VPU_OP_UP_INS_FP:  sidx = iw - one;
      `VPU_OP_DN_INS_INT: sidx = iw + one;
      `VPU_OP_DN_INS_FP:  sidx = iw + one;
      `VPU_OP_PICK_VEC:   sidx = {{(AW-EW){1'b0}}, idx_data[ix*EW +: EW]};
      `VPU_OP_PICK_HALF:  sidx = {{(AW-`VPU_IDX16_W){1'b0}}, idx16_data[ix*16 +: 16]};
      `VPU_OP_PICK_SCAL:  sidx = offw;
      default:            sidx = iw;
    endcase
  end

  vpu_elem_pick #(
    .EW (EW),
    .NE (NE),
    .IW (AW)
  ) u_pick (
    .sel_vec  (src_data),
    .sel_idx  (sidx),
    .sel_lim  (mxw),
    .sel_data (pick_data)
  );

  always @*
  begin
    elem_val = pick_data;
    if (is_up && i_reg == {CW{1'b0}})
      elem_val = ins_val;
    else if (is_dn1 && (iw + one) == vlw)
      elem_val = ins_val;
  end

  always @(posedge sys_clk or negedge arst_n)
  begin
    if (!arst_n)
    begin
      state_reg       <= ST_IDLE;
      op_reg          <= `VPU_OP_SLIDE_UP;
      off_reg         <= {SCALAR_WIDTH{1'b0}};
      um_reg          <= 1'b1;
      ta_reg          <= 1'b0;
      ma_reg          <= 1'b0;
      i_reg           <= {CW{1'b0}};
      wptr_reg        <= {CW{1'b0}};
      busy_reg        <= 1'b0;
      done_reg        <= 1'b0;
      reserved_reg    <= 1'b0;
      illegal_reg     <= 1'b0;
      fault_start_reg <= {CW{1'b0}};
      result_reg      <= {NE*EW{1'b0}};
      elem_we_reg     <= {NE{1'b0}};
    end
    else
    begin
      done_reg     <= 1'b0;
      reserved_reg <= 1'b0;
      illegal_reg  <= 1'b0;
      case (state_reg)
        ST_IDLE:
        begin
          if (start_req)
          begin
            op_reg      <= op_code;
            off_reg     <= off_in;
            um_reg      <= unmasked_flag;
            ta_reg      <= tail_agnostic;
            ma_reg      <= mask_agnostic;
            i_reg       <= {CW{1'b0}};
            wptr_reg    <= {CW{1'b0}};
            result_reg  <= dest_old;
            elem_we_reg <= {NE{1'b0}};
            // compress restarts from element 0, so that is what a trap reports
            fault_start_reg <= (op_code == `VPU_OP_COMPRESS) ? {CW{1'b0}} : start_index;
            if (rsv)
            begin
              reserved_reg <= 1'b1;
              done_reg     <= 1'b1;
            end
            else if (op_code == `VPU_OP_COMPRESS && start_index != {CW{1'b0}})
            begin
              illegal_reg <= 1'b1;
              done_reg    <= 1'b1;
            end
            else if (op_code != `VPU_OP_COMPRESS && start_index >= active_length)
              done_reg <= 1'b1;
            else
            begin
              busy_reg  <= 1'b1;
              state_reg <= ST_RUN;
            end
          end
        end
        ST_RUN:
        begin
          if (is_cmp)
          begin
            if (i_reg < active_length && mask_bits[ix])
            begin
              result_reg[wx*EW +: EW] <= pick_data;
              elem_we_reg[wx]         <= 1'b1;
              wptr_reg                <= wptr_reg + 1'b1;
            end
          end
          else if (i_reg < start_index)
            ;
          else if (i_reg >= active_length)
          begin
            if (ta_reg)
            begin
              result_reg[ix*EW +: EW] <= ones;
              elem_we_reg[ix]         <= 1'b1;
            end
          end
          else if (op_reg == `VPU_OP_SLIDE_UP && iw < offw)
            ;
          else if (!um_reg && !mask_bits[ix])
          begin
            if (ma_reg)
            begin
              result_reg[ix*EW +: EW] <= ones;
              elem_we_reg[ix]         <= 1'b1;
            end
          end
          else
          begin
            result_reg[ix*EW +: EW] <= elem_val;
            elem_we_reg[ix]         <= 1'b1;
          end
          if (i_reg == LAST)
          begin
            if (is_cmp)
            begin
              // the last element may be packed this cycle, so the tail starts one past the write pointer
              if (i_reg < active_length && mask_bits[ix] && wptr_reg == LAST)
              begin
                busy_reg  <= 1'b0;
                done_reg  <= 1'b1;
                state_reg <= ST_IDLE;
              end
              else if (i_reg < active_length && mask_bits[ix])
              begin
                i_reg     <= wptr_reg + 1'b1;
                state_reg <= ST_TAIL;
              end
              else
              begin
                i_reg     <= wptr_reg;
                state_reg <= ST_TAIL;
              end
            end
            else
            begin
              busy_reg  <= 1'b0;
              done_reg  <= 1'b1;
              state_reg <= ST_IDLE;
            end
          end
          else
            i_reg <= i_reg + 1'b1;
        end
        ST_TAIL:
        begin
          if (ta_reg)
          begin
            result_reg[ix*EW +: EW] <= ones;
            elem_we_reg[ix]         <= 1'b1;
          end
          if (i_reg == LAST)
          begin
            busy_reg  <= 1'b0;
            done_reg  <= 1'b1;
            state_reg <= ST_IDLE;
          end
          else
            i_reg <= i_reg + 1'b1;
        end
        default:
        begin
          busy_reg  <= 1'b0;
          state_reg <= ST_IDLE;
        end
      endcase
    end
  end
endmodule

// ===== tb/vpu_issue_model.sv
`timescale 1ns/1ps
module vpu_issue_model (
  // clock and reset
  input  wire sys_clk,
  input  wire arst_n,
  // bench request and unit state
  input  wire go,
  input  wire busy_reg,
  output reg  start_req
);
  // one request per go; it drops at the edge that takes it, so no second start
  always @(posedge sys_clk or negedge arst_n)
  begin
    if (!arst_n)
      start_req <= 1'b0;
    else if (start_req && !busy_reg)
      start_req <= 1'b0;
    else if (go)
      start_req <= 1'b1;
  end
endmodule

// ===== tb/vpu_permute_monitor.sv
`timescale 1ns/1ps
`include "vpu_consts.vh"
module vpu_permute_monitor #(
  parameter EW   = 32,
  parameter NE   = 8,
  parameter SCALAR_WIDTH = 64,
  parameter FLEN = 32
) (
  // clock and reset
  input wire                  sys_clk,
  input wire                  arst_n,
  // request
  input wire                  start_req,
  input wire [`VPU_OP_W-1:0]  op_code,
  input wire                  use_imm,
  input wire [`VPU_IMM_W-1:0] imm_offset,
  input wire                  unmasked_flag,
  input wire                  tail_agnostic,
  input wire [$clog2(NE):0]   active_length,
  input wire [$clog2(NE):0]   start_index,
  input wire [SCALAR_WIDTH-1:0]       scalar_int,
  input wire [FLEN-1:0]       scalar_float,
  input wire [NE*EW-1:0]      dest_old,
  // results
  input wire                  busy_reg,
  input wire                  done_reg,
  input wire                  reserved_reg,
  input wire                  illegal_reg,
  input wire [$clog2(NE):0]   fault_start_reg,
  input wire [NE*EW-1:0]      result_reg,
  input wire [NE-1:0]         elem_we_reg
);
  default clocking cb @(posedge sys_clk); endclocking
  default disable iff (!arst_n);
  wire cmp = op_code == `VPU_OP_COMPRESS;
  wire fin = done_reg && !reserved_reg;
  done_pulse_a: assert property (done_reg |=> !done_reg) else $error("done held");
  busy_end_a: assert property ($fell(busy_reg) |-> done_reg) else $error("busy ended without done");
  rsv_nowrite_a: assert property (reserved_reg |-> done_reg && elem_we_reg == 0 && result_reg == dest_old)
    else $error("reserved op wrote");
  ill_cause_a: assert property (fin && cmp && start_index != 0 |-> illegal_reg) else $error("no illegal flag");
  fault_zero_a: assert property (done_reg && cmp |-> fault_start_reg == 0) else $error("fault start not zero");
  noop_fast_a: assert property (start_req && !busy_reg && !cmp && start_index >= active_length |=> done_reg)
    else $error("no-op slow");
  noop_write_a: assert property (fin && !cmp && start_index >= active_length |-> elem_we_reg == 0)
    else $error("no-op wrote");
  tail_keep_a: assert property (fin && !cmp && !tail_agnostic && active_length < NE |-> !elem_we_reg[NE-1])
    else $error("tail written");
  up_gap_a: assert property (done_reg && op_code == `VPU_OP_SLIDE_UP && use_imm && imm_offset != 0 |-> !elem_we_reg[0])
    else $error("below offset written");
  ins_int_a: assert property (fin && op_code == `VPU_OP_UP_INS_INT && start_index == 0 && active_length != 0
    && unmasked_flag |-> elem_we_reg[0] && result_reg[EW-1:0] == scalar_int[EW-1:0]) else $error("int insert");
  ins_fp_a: assert property (fin && op_code == `VPU_OP_UP_INS_FP && start_index == 0 && active_length != 0
    && unmasked_flag |-> elem_we_reg[0] && result_reg[EW-1:0] == scalar_float[EW-1:0]) else $error("float insert");
endmodule
bind vpu_permute vpu_permute_monitor #(.EW(EW), .NE(NE), .SCALAR_WIDTH(SCALAR_WIDTH), .FLEN(FLEN)) mon (
  .sys_clk(sys_clk), .arst_n(arst_n), .start_req(start_req), .op_code(op_code), .use_imm(use_imm),
  .imm_offset(imm_offset), .unmasked_flag(unmasked_flag), .tail_agnostic(tail_agnostic),
  .active_length(active_length), .start_index(start_index), .scalar_int(scalar_int),
  .scalar_float(scalar_float), .dest_old(dest_old), .busy_reg(busy_reg), .done_reg(done_reg),
  .reserved_reg(reserved_reg), .illegal_reg(illegal_reg), .fault_start_reg(fault_start_reg),
  .result_reg(result_reg), .elem_we_reg(elem_we_reg));

// ===== tb/vpu_permute_tb.sv
`timescale 1ns/1ps
`include "vpu_consts.vh"
module vpu_permute_tb;
  localparam EW = 32;
  localparam NE = 8;
  localparam W  = NE*EW;
  reg            sys_clk = 1'b0, arst_n = 1'b0, go = 1'b0;
  reg            use_imm = 1'b0, unmasked_flag = 1'b1, tail_agnostic = 1'b0, mask_agnostic = 1'b0;
  reg  [3:0]     op_code = 4'h0, active_length = 4'h0, start_index = 4'h0, max_element_count = 4'h8;
  reg  [3:0]     data_grp = 4'h1, idx_grp = 4'h1;
  reg  [4:0]     imm_offset = 5'h0, dst_reg = 5'h0, src_reg = 5'h8, idx_reg = 5'h10;
  reg  [63:0]    scalar_int = 64'h0;
  reg  [31:0]    scalar_float = 32'h0;
  reg  [W-1:0]   src_data = 256'h0, idx_data = 256'h0, dest_old = 256'h0, er;
  reg  [127:0]   idx16_data = 128'h0;
  reg  [NE-1:0]  mask_bits = 8'h0, ew;
  reg            ers, eil;
  wire           start_req, busy_reg, done_reg, reserved_reg, illegal_reg;
  wire [3:0]     fault_start_reg;
  wire [W-1:0]   result_reg;
  wire [NE-1:0]  elem_we_reg;
  integer        mismatches = 0, checks = 0, seed = 19, n, t;
  always #5 sys_clk = ~sys_clk;
  vpu_permute #(.EW(EW), .NE(NE), .SCALAR_WIDTH(64), .FLEN(32)) dut (
    .sys_clk(sys_clk), .arst_n(arst_n), .start_req(start_req), .op_code(op_code), .use_imm(use_imm),
    .imm_offset(imm_offset), .unmasked_flag(unmasked_flag), .tail_agnostic(tail_agnostic),
    .mask_agnostic(mask_agnostic), .active_length(active_length), .start_index(start_index),
    .max_element_count(max_element_count), .dst_reg(dst_reg), .src_reg(src_reg), .idx_reg(idx_reg),
    .data_grp(data_grp), .idx_grp(idx_grp), .scalar_int(scalar_int), .scalar_float(scalar_float),
    .src_data(src_data), .idx_data(idx_data), .idx16_data(idx16_data), .mask_bits(mask_bits),
    .dest_old(dest_old), .busy_reg(busy_reg), .done_reg(done_reg), .reserved_reg(reserved_reg),
    .illegal_reg(illegal_reg), .fault_start_reg(fault_start_reg), .result_reg(result_reg),
    .elem_we_reg(elem_we_reg));
  vpu_issue_model prt (.sys_clk(sys_clk), .arst_n(arst_n), .go(go), .busy_reg(busy_reg), .start_req(start_req));
  task chk(input [W-1:0] s, input [W-1:0] e);
    begin
      checks = checks + 1;
      if (s !== e)
      begin
        mismatches = mismatches + 1;
        $display("unexpected at %0t: saw %h want %h", $time, s, e);
      end
    end
  endtask
  function ov(input integer b, input integer g);
    ov = dst_reg < b + g && b < dst_reg + data_grp;
  endfunction
  task wr(input integer k, input [EW-1:0] v);
    begin
      er[k*EW+:EW] = v;
      ew[k] = 1'b1;
    end
  endtask
  task model;
    integer k, j, p, o;
    reg [EW-1:0] v;
    reg sc;
    begin
      er = dest_old;
      ew = 0;
      p = 0;
      o = use_imm ? imm_offset : (scalar_int > 64'hFF ? 999 : scalar_int);
      case (op_code)
        `VPU_OP_SLIDE_DN, `VPU_OP_DN_INS_INT, `VPU_OP_DN_INS_FP: ers = 0;
        `VPU_OP_PICK_VEC: ers = ov(src_reg, data_grp) | ov(idx_reg, data_grp);
        `VPU_OP_PICK_HALF: ers = ov(src_reg, data_grp) | ov(idx_reg, idx_grp);
        `VPU_OP_COMPRESS: ers = ov(src_reg, data_grp) | ov(idx_reg, 1) | !unmasked_flag;
        default: ers = ov(src_reg, data_grp);
      endcase
      eil = !ers && op_code == `VPU_OP_COMPRESS && start_index != 0;
      if (!ers && !eil && op_code == `VPU_OP_COMPRESS)
      begin
        for (k = 0; k < NE; k = k + 1)
          if (k < active_length && mask_bits[k]) begin wr(p, src_data[k*EW+:EW]); p = p + 1; end
        for (k = p; k < NE; k = k + 1)
          if (tail_agnostic) wr(k, {EW{1'b1}});
      end
      else if (!ers && op_code != `VPU_OP_COMPRESS && start_index < active_length)
        for (k = start_index; k < NE; k = k + 1)
        begin
          sc = 0;
          case (op_code)
            `VPU_OP_SLIDE_UP: j = k - o;
            `VPU_OP_SLIDE_DN: j = k + o;
            `VPU_OP_UP_INS_INT, `VPU_OP_UP_INS_FP: begin j = k - 1; sc = k == 0; end
            `VPU_OP_DN_INS_INT, `VPU_OP_DN_INS_FP: begin j = k + 1; sc = k == active_length - 1; end
            `VPU_OP_PICK_VEC: j = idx_data[k*EW+:EW];
            `VPU_OP_PICK_HALF: j = idx16_data[k*16+:16];
            default: j = o;
          endcase
          v = (j < 0 || j >= max_element_count) ? 0 : src_data[j*EW+:EW];
          if (sc) v = (op_code == `VPU_OP_UP_INS_FP || op_code == `VPU_OP_DN_INS_FP) ? scalar_float : scalar_int;
          if (k >= active_length) begin if (tail_agnostic) wr(k, {EW{1'b1}}); end
          else if (op_code == `VPU_OP_SLIDE_UP && k < o) ;
          else if (!(unmasked_flag | mask_bits[k])) begin if (mask_agnostic) wr(k, {EW{1'b1}}); end
          else wr(k, v);
        end
    end
  endtask
  task rnd(input [3:0] op);
    integer k;
    reg [31:0] r;
    reg [W-1:0] a, b, c;
    reg [127:0] h;
    begin
      r = $random(seed);
      for (k = 0; k < NE; k = k + 1)
      begin
        a[k*EW+:EW] = $random(seed);
        b[k*EW+:EW] = $random(seed) & 15;
        c[k*EW+:EW] = $random(seed);
        h[k*16+:16] = $random(seed) & 15;
      end
      @(posedge sys_clk);
      op_code <= op;
      {unmasked_flag, tail_agnostic, mask_agnostic, use_imm, imm_offset} <= r[8:0];
      max_element_count <= 4'h5 + r[10:9];
      active_length <= r[15:12] % (4'h6 + r[10:9]);
      start_index <= r[17:16] == 0 ? r[21:18] % 9 : 0;
      {data_grp, idx_grp} <= {4'h1 + r[22], 4'h1 + r[23]};
      {dst_reg, src_reg, idx_reg} <= 15'h0110;
      scalar_int <= r[24] ? {$random(seed), $random(seed)} : r[28:25];
      scalar_float <= $random(seed);
      mask_bits <= $random(seed);
      {src_data, idx_data, dest_old, idx16_data} <= {a, b, c, h};
    end
  endtask
  task run;
    begin
      @(posedge sys_clk) go <= 1'b1;
      @(posedge sys_clk) go <= 1'b0;
      n = 0;
      while (done_reg !== 1'b1 && n < 40) begin @(posedge sys_clk); #1; n = n + 1; end
      chk(n < 40, 1);
      model;
      chk(result_reg, er);
      chk(elem_we_reg, ew);
      chk(reserved_reg, ers);
      chk(illegal_reg, eil);
      chk(fault_start_reg, op_code == `VPU_OP_COMPRESS ? 0 : start_index);
    end
  endtask
  task finish_test;
    begin
      $display("checks %0d mismatches %0d", checks, mismatches);
      if (mismatches == 0 && checks > 0)
        $display("Testbench passed");
      else
        $display("Testbench failed");
      $finish;
    end
  endtask
  // watchdog: the whole run needs about 2500 cycles
  initial
  begin
    #200000;
    chk(0, 1);
    finish_test;
  end
  initial
  begin
    repeat (8) @(posedge sys_clk);
    arst_n <= 1'b1;
    for (t = 0; t < 250; t = t + 1) begin rnd(t % 10); run; end
    $display("random test done");
    // overlapping groups make every non-down op reserved
    for (t = 0; t < 10; t = t + 1) begin rnd(t); @(posedge sys_clk) {src_reg, data_grp} <= 9'h12; run; end
    rnd(`VPU_OP_PICK_VEC);
    @(posedge sys_clk) idx_reg <= 5'h0;
    run;
    rnd(`VPU_OP_COMPRESS);
    @(posedge sys_clk) idx_reg <= 5'h0;
    run;
    rnd(`VPU_OP_COMPRESS);
    @(posedge sys_clk) {unmasked_flag, start_index} <= 5'h11;
    run;
    // last element packed with a short packed count: the tail must still be filled
    rnd(`VPU_OP_COMPRESS);
    @(posedge sys_clk) {unmasked_flag, tail_agnostic, start_index, active_length, max_element_count, mask_bits}
      <= {2'h3, 4'h0, 4'h8, 4'h8, 8'hA5};
    run;
    $display("directed test done");
    finish_test;
  end
endmodule
